//--- src/opvd_pkg.sv
// Package for the operand format and vector decode block: constants, modes and carriers.
// Assumes a single CPU clock domain and an asynchronous active-high reset.
package opvd_pkg;

	localparam logic [19:0] TBASE_RESET      = 20'h00000;
	localparam logic [19:0] SPECIAL_TOP      = 20'hffffe;
	localparam logic [19:0] SPECIAL_START    = 20'hffe00;
	localparam logic [19:0] SPECIAL_END      = 20'hfffdb;
	localparam logic [7:0]  SPECIAL_MIN_NUM  = 8'h12;
	localparam logic [3:0]  SPECIAL_HI_NIB   = 4'hf;
	localparam logic [19:0] FIXED_INT_START  = 20'hfffdc;
	localparam logic [19:0] FIXED_INT_END    = 20'hfffff;
	localparam logic [7:0]  FIXED_INT_MAX    = 8'h08;
	localparam logic [8:0]  VEC_TABLE_BYTES  = 9'h100;
	localparam logic [7:0]  SOFT_INT_MAX     = 8'h3f;
	localparam logic [7:0]  PERIPH_INT_MAX   = 8'h1f;
	localparam logic [2:0]  SPECIAL_ENTRY_B  = 3'h2;
	localparam logic [2:0]  INT_ENTRY_B      = 3'h4;
	localparam logic [16:0] ABS_BIT_LIMIT    = 17'h01fff;
	localparam logic [16:0] STATIC8_LIMIT    = 17'h0001f;
	localparam logic [16:0] STATIC11_LIMIT   = 17'h000ff;
	localparam logic [16:0] STATIC16_LIMIT   = 17'h01fff;
	localparam logic [16:0] FRAME_LOW_OFS    = 17'h1fff0;
	localparam logic [16:0] FRAME_HIGH_OFS   = 17'h0000f;
	localparam logic [3:0]  OPC_LONG_BYTES   = 4'h2;
	localparam logic [3:0]  OPC_SHORT_BYTES  = 4'h1;
	localparam logic [1:0]  FIELD_MAX_SHORT  = 2'h2;
	localparam int          QUICK_IMM_LSB    = 4;
	localparam logic [3:0]  QUICK_PLUS8_CODE = 4'h8;
	localparam logic [7:0]  QUICK_PLUS8_VAL  = 8'h08;

	typedef enum logic [2:0] {
		OPVD_BIT_REG, OPVD_BIT_ABS, OPVD_BIT_STATIC, OPVD_BIT_FRAME, OPVD_BIT_AN_IND, OPVD_BIT_AN_REL
	} opvd_bit_mode_t;
	typedef enum logic [1:0] {OPVD_BASE8, OPVD_BASE11, OPVD_BASE16} opvd_base_size_t;
	typedef enum logic [1:0] {OPVD_FMT_G, OPVD_FMT_Q, OPVD_FMT_S, OPVD_FMT_Z} opvd_fmt_t;
	typedef enum logic [1:0] {
		OPVD_VEC_SPECIAL, OPVD_VEC_FIXED, OPVD_VEC_SOFT, OPVD_VEC_PERIPH
	} opvd_vec_kind_t;
	typedef enum logic [1:0] {
		OPVD_STR_FWD, OPVD_STR_BWD, OPVD_STR_FILL
	} opvd_str_op_t;

	typedef struct packed {
		opvd_bit_mode_t  mode;
		opvd_base_size_t bsize;
		logic [15:0]     base;
		logic [15:0]     bitnum;
		logic [15:0]     addr_reg_n;
		logic [15:0]     static_base_reg;
		logic [15:0]     frame_base_reg;
	} opvd_bit_req_t;
	typedef struct packed {
		logic        is_reg;
		logic [19:0] byte_addr;
		logic [3:0]  bit_idx;
		logic        range_err;
	} opvd_bit_res_t;
	typedef struct packed {
		opvd_fmt_t   fmt;
		logic [1:0]  src_bytes;
		logic [1:0]  dst_bytes;
		logic        quick_plus8;
		logic [15:0] opcode;
		logic        int_signed;
		logic        int_word;
		logic [15:0] int_data;
	} opvd_len_req_t;
	typedef struct packed {
		logic [3:0]  total;
		logic [7:0]  imm;
		logic        len_err;
		logic [16:0] int_value;
	} opvd_len_res_t;

endpackage

//--- src/opvd_bitaddr.sv
// Combinational bit operand locator for register and memory bit addressing.
// Assumes the caller registers the result; base registers arrive in the request.
`timescale 1ns/1ps
`default_nettype none
module opvd_bitaddr (
	input  wire opvd_pkg::opvd_bit_req_t req,
	output opvd_pkg::opvd_bit_res_t      res
);

	function automatic logic [16:0] locate(input logic [16:0] ofs, input logic [15:0] cnt);
		locate = ofs + {4'h0, cnt[15:3]};
	endfunction

	function automatic logic [16:0] base_field(input opvd_pkg::opvd_base_size_t sz,
		input logic [15:0] b);
		case (sz)
			opvd_pkg::OPVD_BASE8:  base_field = {9'h000, b[7:0]};
			opvd_pkg::OPVD_BASE11: base_field = {6'h00, b[10:0]};
			default:               base_field = {1'b0, b};
		endcase
	endfunction

	logic [16:0] rel;
	logic [16:0] lim;

	always_comb
	begin
		res = '0;
		rel = '0;
		lim = opvd_pkg::STATIC16_LIMIT;
		res.bit_idx = {1'b0, req.bitnum[2:0]};
		case (req.mode)
			opvd_pkg::OPVD_BIT_REG:
			begin
				res.is_reg = 1'b1;
				res.bit_idx = req.bitnum[3:0];
				res.range_err = |req.bitnum[15:4];
			end
			opvd_pkg::OPVD_BIT_ABS:
			begin
				rel = locate({1'b0, req.base}, req.bitnum);
				res.byte_addr = {4'h0, rel[15:0]};
				res.range_err = rel > opvd_pkg::ABS_BIT_LIMIT;
			end
			opvd_pkg::OPVD_BIT_STATIC:
			begin
				if (req.bsize == opvd_pkg::OPVD_BASE8)
					lim = opvd_pkg::STATIC8_LIMIT;
				else if (req.bsize == opvd_pkg::OPVD_BASE11)
					lim = opvd_pkg::STATIC11_LIMIT;
				rel = locate(base_field(req.bsize, req.base), req.bitnum);
				res.byte_addr = {4'h0, req.static_base_reg + rel[15:0]};
				res.range_err = rel > lim;
			end
			opvd_pkg::OPVD_BIT_FRAME:
			begin
				rel = locate({{9{req.base[7]}}, req.base[7:0]}, req.bitnum);
				res.byte_addr = {4'h0, req.frame_base_reg + rel[15:0]};
				res.range_err = ($signed(rel) < $signed(opvd_pkg::FRAME_LOW_OFS))
					|| ($signed(rel) > $signed(opvd_pkg::FRAME_HIGH_OFS));
			end
			opvd_pkg::OPVD_BIT_AN_IND:
			begin
				rel = locate(17'h00000, req.addr_reg_n);
				res.byte_addr = {4'h0, rel[15:0]};
				res.bit_idx = {1'b0, req.addr_reg_n[2:0]};
			end
			opvd_pkg::OPVD_BIT_AN_REL:
			begin
				rel = locate(base_field(req.bsize, req.base), req.addr_reg_n);
				res.byte_addr = {4'h0, rel[15:0]};
				res.bit_idx = {1'b0, req.addr_reg_n[2:0]};
			end
			default:
			begin
				res.range_err = 1'b1;
			end
		endcase
	end

endmodule
`default_nettype wire

//--- src/opvd_fmtlen.sv
// Combinational instruction length, quick immediate and integer widening.
// Assumes the caller supplies operand byte counts already split from the op-code.
`timescale 1ns/1ps
`default_nettype none
module opvd_fmtlen (
	input  wire opvd_pkg::opvd_len_req_t req,
	output opvd_pkg::opvd_len_res_t      res
);

	logic [3:0] nib;

	always_comb
	begin
		res = '0;
		nib = req.opcode[opvd_pkg::QUICK_IMM_LSB +: 4];
		case (req.fmt)
			opvd_pkg::OPVD_FMT_G:
				res.total = opvd_pkg::OPC_LONG_BYTES + {2'h0, req.src_bytes}
					+ {2'h0, req.dst_bytes};
			opvd_pkg::OPVD_FMT_Q:
			begin
				res.total = opvd_pkg::OPC_LONG_BYTES + {2'h0, req.dst_bytes};
				res.len_err = req.dst_bytes > opvd_pkg::FIELD_MAX_SHORT;
				// The plus-eight variant reuses the code that would otherwise mean minus eight.
				if (req.quick_plus8 && nib == opvd_pkg::QUICK_PLUS8_CODE)
					res.imm = opvd_pkg::QUICK_PLUS8_VAL;
				else
					res.imm = {{4{nib[3]}}, nib};
			end
			opvd_pkg::OPVD_FMT_S:
			begin
				res.total = opvd_pkg::OPC_SHORT_BYTES + {2'h0, req.src_bytes}
					+ {2'h0, req.dst_bytes};
				res.len_err = (req.src_bytes > opvd_pkg::FIELD_MAX_SHORT)
					|| (req.dst_bytes > opvd_pkg::FIELD_MAX_SHORT);
			end
			default:
			begin
				res.total = opvd_pkg::OPC_SHORT_BYTES + {2'h0, req.dst_bytes};
				res.len_err = req.dst_bytes > opvd_pkg::FIELD_MAX_SHORT;
				res.imm = 8'h00;
			end
		endcase
		if (req.int_word)
			res.int_value = {req.int_signed & req.int_data[15], req.int_data};
		else
			res.int_value = {{9{req.int_signed & req.int_data[7]}}, req.int_data[7:0]};
	end

endmodule
`default_nettype wire

//--- src/opvd_decode.sv
// Top of the operand format and vector decode block.
// Assumes requests are synchronous to CLK and the memory bus answers one byte per acknowledge.
`timescale 1ns/1ps
`default_nettype none
module opvd_decode (
	input  wire logic                     CLK,
	input  wire logic                     RST,
	input  wire logic                     BIT_REQ,
	input  wire opvd_pkg::opvd_bit_req_t  BIT_ARGS,
	output logic                          BIT_VALID,
	output opvd_pkg::opvd_bit_res_t       BIT_RESULT,
	input  wire logic                     LEN_REQ,
	input  wire opvd_pkg::opvd_len_req_t  LEN_ARGS,
	output logic                          LEN_VALID,
	output opvd_pkg::opvd_len_res_t       LEN_RESULT,
	input  wire logic                     STR_REQ,
	input  wire opvd_pkg::opvd_str_op_t   STR_OP,
	input  wire logic                     STR_WORD,
	input  wire logic [19:0]              STR_ADDR,
	input  wire logic [15:0]              STR_COUNT,
	output logic                          STR_VALID,
	output logic [19:0]                   STR_NEXT_ADDR,
	output logic [15:0]                   STR_NEXT_COUNT,
	output logic [1:0]                    STR_ELEM_BYTES,
	output logic                          STR_DONE,
	input  wire logic                     TBASE_WE,
	input  wire logic [19:0]              TBASE_WDATA,
	output logic [19:0]                   TBASE_VALUE,
	input  wire logic                     VEC_REQ,
	input  wire opvd_pkg::opvd_vec_kind_t VEC_KIND,
	input  wire logic [7:0]               VEC_NUM,
	output logic                          VEC_BUSY,
	output logic                          VEC_DONE,
	output logic                          VEC_ERR,
	output logic [19:0]                   VEC_ENTRY_ADDR,
	output logic [19:0]                   VEC_HANDLER,
	output logic                          MEM_RD,
	output logic [19:0]                   MEM_ADDR,
	input  wire logic                     MEM_ACK,
	input  wire logic [7:0]               MEM_RDATA
);

	typedef enum logic {OPVD_IDLE, OPVD_FETCH} opvd_state_t;

	opvd_pkg::opvd_bit_res_t bit_next;
	opvd_pkg::opvd_len_res_t len_next;

	opvd_state_t              state_reg;
	opvd_pkg::opvd_vec_kind_t kind_reg;
	logic [19:0]              tbase_reg;
	logic [1:0]               lane_reg;
	logic [2:0]               nbytes_reg;
	logic [31:0]              data_reg;
	logic [31:0]              data_next;
	logic [19:0]              handler_next;
	logic [19:0]              entry_next;
	logic [2:0]               entry_bytes;
	logic                     entry_err;
	logic [19:0]              str_step;
	logic                     last_ack;

	opvd_bitaddr u_bitaddr (
		.req (BIT_ARGS),
		.res (bit_next)
	);

	opvd_fmtlen u_fmtlen (
		.req (LEN_ARGS),
		.res (len_next)
	);

	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
		begin
			BIT_VALID <= 1'b0;
			BIT_RESULT <= '0;
		end
		else
		begin
			BIT_VALID <= BIT_REQ;
			if (BIT_REQ)
				BIT_RESULT <= bit_next;
		end
	end

	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
		begin
			LEN_VALID <= 1'b0;
			LEN_RESULT <= '0;
		end
		else
		begin
			LEN_VALID <= LEN_REQ;
			if (LEN_REQ)
				LEN_RESULT <= len_next;
		end
	end

	// String stepping: one element per request, address moves by the element size unless the count is already zero.
	always_comb
	begin
		str_step = STR_WORD ? 20'h00002 : 20'h00001;
	end

	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
		begin
			STR_VALID <= 1'b0;
			STR_NEXT_ADDR <= '0;
			STR_NEXT_COUNT <= '0;
			STR_ELEM_BYTES <= 2'h0;
			STR_DONE <= 1'b0;
		end
		else
		begin
			STR_VALID <= STR_REQ;
			if (STR_REQ)
			begin
				STR_ELEM_BYTES <= STR_WORD ? 2'h2 : 2'h1;
				if (STR_COUNT == 16'h0000)
				begin
					STR_NEXT_ADDR <= STR_ADDR;
					STR_NEXT_COUNT <= 16'h0000;
					STR_DONE <= 1'b1;
				end
				else
				begin
					case (STR_OP)
						opvd_pkg::OPVD_STR_BWD:
							STR_NEXT_ADDR <= STR_ADDR - str_step;
						default:
							STR_NEXT_ADDR <= STR_ADDR + str_step;
					endcase
					STR_NEXT_COUNT <= STR_COUNT - 16'h0001;
					STR_DONE <= STR_COUNT == 16'h0001;
				end
			end
		end
	end

	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
			tbase_reg <= opvd_pkg::TBASE_RESET;
		else if (TBASE_WE)
			tbase_reg <= TBASE_WDATA;
	end

	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
			TBASE_VALUE <= opvd_pkg::TBASE_RESET;
		else if (TBASE_WE)
			TBASE_VALUE <= TBASE_WDATA;
	end

	// Entry address for each vector kind. Out-of-range numbers are refused without a fetch.
	always_comb
	begin
		entry_next = '0;
		entry_bytes = opvd_pkg::INT_ENTRY_B;
		entry_err = 1'b0;
		case (VEC_KIND)
			opvd_pkg::OPVD_VEC_SPECIAL:
			begin
				entry_next = opvd_pkg::SPECIAL_TOP - {11'h000, VEC_NUM, 1'b0};
				entry_bytes = opvd_pkg::SPECIAL_ENTRY_B;
				entry_err = VEC_NUM < opvd_pkg::SPECIAL_MIN_NUM;
			end
			opvd_pkg::OPVD_VEC_FIXED:
			begin
				entry_next = opvd_pkg::FIXED_INT_START + {10'h000, VEC_NUM, 2'b00};
				entry_err = VEC_NUM > opvd_pkg::FIXED_INT_MAX;
			end
			opvd_pkg::OPVD_VEC_SOFT:
			begin
				entry_next = tbase_reg + {10'h000, VEC_NUM, 2'b00};
				entry_err = VEC_NUM > opvd_pkg::SOFT_INT_MAX;
			end
			opvd_pkg::OPVD_VEC_PERIPH:
			begin
				entry_next = tbase_reg + {10'h000, VEC_NUM, 2'b00};
				entry_err = VEC_NUM > opvd_pkg::PERIPH_INT_MAX;
			end
			default:
			begin
				entry_err = 1'b1;
			end
		endcase
	end

	// Each arriving byte drops into the lane of its order, lowest address lowest.
	always_comb
	begin
		data_next = data_reg;
		case (lane_reg)
			2'h0: data_next[7:0] = MEM_RDATA;
			2'h1: data_next[15:8] = MEM_RDATA;
			2'h2: data_next[23:16] = MEM_RDATA;
			default: data_next[31:24] = MEM_RDATA;
		endcase
		if (kind_reg == opvd_pkg::OPVD_VEC_SPECIAL)
			handler_next = {opvd_pkg::SPECIAL_HI_NIB, data_next[15:0]};
		else
			handler_next = data_next[19:0];
		last_ack = MEM_ACK && ({1'b0, lane_reg} == nbytes_reg - 3'h1);
	end

	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
		begin
			state_reg <= OPVD_IDLE;
			kind_reg <= opvd_pkg::OPVD_VEC_SPECIAL;
			lane_reg <= 2'h0;
			nbytes_reg <= 3'h0;
			data_reg <= '0;
		end
		else
		begin
			case (state_reg)
				OPVD_IDLE:
				begin
					if (VEC_REQ && !entry_err)
					begin
						state_reg <= OPVD_FETCH;
						kind_reg <= VEC_KIND;
						lane_reg <= 2'h0;
						nbytes_reg <= entry_bytes;
						data_reg <= '0;
					end
				end
				OPVD_FETCH:
				begin
					if (MEM_ACK)
					begin
						data_reg <= data_next;
						lane_reg <= lane_reg + 2'h1;
					end
					if (last_ack)
						state_reg <= OPVD_IDLE;
				end
				default:
				begin
					state_reg <= OPVD_IDLE;
				end
			endcase
		end
	end

	// The read strobe is held with its address until the bus acknowledges each byte.
	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
		begin
			MEM_RD <= 1'b0;
			MEM_ADDR <= '0;
		end
		else if (state_reg == OPVD_IDLE)
		begin
			MEM_RD <= VEC_REQ && !entry_err;
			if (VEC_REQ && !entry_err)
				MEM_ADDR <= entry_next;
		end
		else if (MEM_ACK)
		begin
			MEM_RD <= !last_ack;
			MEM_ADDR <= MEM_ADDR + 20'h00001;
		end
	end

	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
			VEC_BUSY <= 1'b0;
		else if (state_reg == OPVD_IDLE)
			VEC_BUSY <= VEC_REQ && !entry_err;
		else if (last_ack)
			VEC_BUSY <= 1'b0;
	end

	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
		begin
			VEC_DONE <= 1'b0;
			VEC_ERR <= 1'b0;
			VEC_ENTRY_ADDR <= '0;
			VEC_HANDLER <= '0;
		end
		else
		begin
			VEC_DONE <= 1'b0;
			if (state_reg == OPVD_IDLE && VEC_REQ)
			begin
				VEC_ENTRY_ADDR <= entry_next;
				VEC_ERR <= entry_err;
				VEC_DONE <= entry_err;
			end
			else if (state_reg == OPVD_FETCH && last_ack)
			begin
				VEC_HANDLER <= handler_next;
				VEC_ERR <= 1'b0;
				VEC_DONE <= 1'b1;
			end
		end
	end

endmodule
`default_nettype wire

//--- sim/opvd_mem_model.sv
// Behavioural memory bus answering the decode block's byte reads.
// Assumes one read strobe held until acknowledge and one byte per acknowledge.
`timescale 1ns/1ps
`default_nettype none
module opvd_mem_model (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        rd,
	input  wire logic [19:0] addr,
	input  wire logic        slow,
	output logic             ack,
	output logic [7:0]       rdata
);
	logic [1:0] wait_reg;

	// Contents are a fixed function of the address so the bench can predict every byte.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			ack      <= 1'b0;
			rdata    <= 8'h00;
			wait_reg <= 2'h0;
		end
		else if (rd && !ack && wait_reg == 2'h0)
		begin
			ack      <= 1'b1;
			rdata    <= addr[7:0] ^ 8'h5a;
			wait_reg <= slow ? 2'h3 : 2'h0;
		end
		else
		begin
			ack   <= 1'b0;
			// A released bus shows the last byte inverted on the next cycle, so a capture one cycle late is caught.
			rdata <= ~rdata;
			if (rd && wait_reg != 2'h0)
				wait_reg <= wait_reg - 2'h1;
		end
	end
endmodule
`default_nettype wire

//--- sim/opvd_decode_assertions.sv
// Port checks for the operand format and vector decode block.
// Assumes one clock domain and is attached to every decode top by bind.
`timescale 1ns/1ps
`default_nettype none
module opvd_decode_assertions (
	input wire logic                     CLK,
	input wire logic                     RST,
	input wire logic                     BIT_REQ,
	input wire opvd_pkg::opvd_bit_req_t  BIT_ARGS,
	input wire opvd_pkg::opvd_bit_res_t  BIT_RESULT,
	input wire logic                     LEN_REQ,
	input wire opvd_pkg::opvd_len_req_t  LEN_ARGS,
	input wire opvd_pkg::opvd_len_res_t  LEN_RESULT,
	input wire logic                     STR_REQ,
	input wire opvd_pkg::opvd_str_op_t   STR_OP,
	input wire logic                     STR_WORD,
	input wire logic [19:0]              STR_ADDR,
	input wire logic [15:0]              STR_COUNT,
	input wire logic [19:0]              STR_NEXT_ADDR,
	input wire logic [1:0]               STR_ELEM_BYTES,
	input wire logic                     TBASE_WE,
	input wire logic [19:0]              TBASE_WDATA,
	input wire logic [19:0]              TBASE_VALUE,
	input wire logic                     VEC_REQ,
	input wire opvd_pkg::opvd_vec_kind_t VEC_KIND,
	input wire logic [7:0]               VEC_NUM,
	input wire logic                     VEC_BUSY,
	input wire logic                     VEC_DONE,
	input wire logic                     VEC_ERR,
	input wire logic                     MEM_RD,
	input wire logic [19:0]              MEM_ADDR,
	input wire logic                     MEM_ACK
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);

	a_reg_bit_index: assert property (BIT_REQ && BIT_ARGS.mode == opvd_pkg::OPVD_BIT_REG
		|=> BIT_RESULT.bit_idx == $past(BIT_ARGS.bitnum[3:0])
		&& BIT_RESULT.range_err == ($past(BIT_ARGS.bitnum) > 16'h000f)) else $error("reg bit wrong");
	a_indirect_bit: assert property (BIT_REQ && BIT_ARGS.mode == opvd_pkg::OPVD_BIT_AN_IND
		|=> BIT_RESULT.byte_addr == {7'h00, $past(BIT_ARGS.addr_reg_n[15:3])}
		&& BIT_RESULT.bit_idx == {1'b0, $past(BIT_ARGS.addr_reg_n[2:0])}) else $error("indirect bit");
	a_generic_len: assert property (LEN_REQ && LEN_ARGS.fmt == opvd_pkg::OPVD_FMT_G
		|=> LEN_RESULT.total == 4'h2 + {2'h0, $past(LEN_ARGS.src_bytes)}
		+ {2'h0, $past(LEN_ARGS.dst_bytes)}) else $error("generic length wrong");
	a_zero_imm: assert property (LEN_REQ && LEN_ARGS.fmt == opvd_pkg::OPVD_FMT_Z
		|=> LEN_RESULT.imm == 8'h00) else $error("zero format immediate not zero");
	a_str_word_step: assert property (STR_REQ && STR_WORD && STR_COUNT != 16'h0000
		&& STR_OP != opvd_pkg::OPVD_STR_BWD |=> STR_NEXT_ADDR == $past(STR_ADDR) + 20'h2
		&& STR_ELEM_BYTES == 2'h2) else $error("word string step wrong");
	a_tbase_write: assert property (TBASE_WE |=> TBASE_VALUE == $past(TBASE_WDATA))
		else $error("table base not written");
	a_soft_entry: assert property (VEC_REQ && !VEC_BUSY && VEC_NUM <= 8'h3f
		&& VEC_KIND == opvd_pkg::OPVD_VEC_SOFT |=> MEM_RD
		&& MEM_ADDR == $past(TBASE_VALUE) + {10'h000, $past(VEC_NUM), 2'h0}) else $error("soft entry");
	a_special_refuse: assert property (VEC_REQ && !VEC_BUSY && VEC_NUM < 8'h12
		&& VEC_KIND == opvd_pkg::OPVD_VEC_SPECIAL |=> VEC_DONE && VEC_ERR && !MEM_RD)
		else $error("special page below 18 accepted");
	a_byte_order: assert property (MEM_RD && MEM_ACK
		|=> !MEM_RD || MEM_ADDR == $past(MEM_ADDR) + 20'h1) else $error("fetch address not rising");
	a_fetch_bound: assert property ($rose(VEC_BUSY) |-> ##[1:64] VEC_DONE)
		else $error("vector fetch hung");

	c_fetch_ok: cover property (VEC_DONE && !VEC_ERR);
	c_fetch_err: cover property (VEC_DONE && VEC_ERR);
	c_bit_err: cover property (BIT_REQ ##1 BIT_RESULT.range_err);
endmodule

bind opvd_decode opvd_decode_assertions u_chk (.CLK, .RST, .BIT_REQ, .BIT_ARGS, .BIT_RESULT,
	.LEN_REQ, .LEN_ARGS, .LEN_RESULT, .STR_REQ, .STR_OP, .STR_WORD, .STR_ADDR, .STR_COUNT,
	.STR_NEXT_ADDR, .STR_ELEM_BYTES, .TBASE_WE, .TBASE_WDATA, .TBASE_VALUE, .VEC_REQ, .VEC_KIND,
	.VEC_NUM, .VEC_BUSY, .VEC_DONE, .VEC_ERR, .MEM_RD, .MEM_ADDR, .MEM_ACK);
`default_nettype wire

//--- sim/opvd_decode_tb_top.sv
// Self-checking bench for the operand format and vector decode block.
// Assumes the memory model beside it answers vector fetches.
`timescale 1ns/1ps
`default_nettype none
module opvd_decode_tb_top;
	logic CLK, RST, BIT_REQ, BIT_VALID, LEN_REQ, LEN_VALID, STR_REQ, STR_WORD, STR_VALID;
	logic STR_DONE, TBASE_WE, VEC_REQ, VEC_BUSY, VEC_DONE, VEC_ERR, MEM_RD, MEM_ACK, slow;
	logic [19:0] STR_ADDR, STR_NEXT_ADDR, TBASE_WDATA, TBASE_VALUE, VEC_ENTRY_ADDR;
	logic [19:0] VEC_HANDLER, MEM_ADDR;
	logic [15:0] STR_COUNT, STR_NEXT_COUNT;
	logic [7:0]  VEC_NUM, MEM_RDATA;
	logic [1:0]  STR_ELEM_BYTES;
	opvd_pkg::opvd_bit_req_t  BIT_ARGS;
	opvd_pkg::opvd_bit_res_t  BIT_RESULT;
	opvd_pkg::opvd_len_req_t  LEN_ARGS;
	opvd_pkg::opvd_len_res_t  LEN_RESULT;
	opvd_pkg::opvd_str_op_t   STR_OP;
	opvd_pkg::opvd_vec_kind_t VEC_KIND;
	int num_errors = 0;
	int checks_done = 0;

	opvd_decode u_dut (.CLK, .RST, .BIT_REQ, .BIT_ARGS, .BIT_VALID, .BIT_RESULT, .LEN_REQ,
		.LEN_ARGS, .LEN_VALID, .LEN_RESULT, .STR_REQ, .STR_OP, .STR_WORD, .STR_ADDR, .STR_COUNT,
		.STR_VALID, .STR_NEXT_ADDR, .STR_NEXT_COUNT, .STR_ELEM_BYTES, .STR_DONE, .TBASE_WE,
		.TBASE_WDATA, .TBASE_VALUE, .VEC_REQ, .VEC_KIND, .VEC_NUM, .VEC_BUSY, .VEC_DONE, .VEC_ERR,
		.VEC_ENTRY_ADDR, .VEC_HANDLER, .MEM_RD, .MEM_ADDR, .MEM_ACK, .MEM_RDATA);
	opvd_mem_model u_mem (.clk(CLK), .rst(RST), .rd(MEM_RD), .addr(MEM_ADDR), .slow(slow),
		.ack(MEM_ACK), .rdata(MEM_RDATA));

	initial
	begin
		CLK = 1'b0;
		forever #2 CLK = ~CLK;
	end

	task automatic test_done;
		$display("mismatches %0d, comparisons %0d", num_errors, checks_done);
		if (num_errors == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
			num_errors++;
		end
	endtask

	// Strobes drop at the next edge and outputs are read once that edge has landed.
	task automatic step;
		@(posedge CLK);
		BIT_REQ <= 1'b0;
		LEN_REQ <= 1'b0;
		STR_REQ <= 1'b0;
		VEC_REQ <= 1'b0;
		TBASE_WE <= 1'b0;
		#1;
	endtask

	task automatic bchk(input opvd_pkg::opvd_bit_mode_t m, input opvd_pkg::opvd_base_size_t s,
			input logic [15:0] b, input logic [15:0] n, input logic [15:0] r,
			input logic [19:0] ea, input logic [3:0] eb, input logic ee);
		@(posedge CLK);
		BIT_REQ  <= 1'b1;
		BIT_ARGS <= '{m, s, b, n, r, r, r};
		step();
		chk(BIT_VALID, 1'b1);
		chk(BIT_RESULT.byte_addr, ea);
		chk(BIT_RESULT.bit_idx, eb);
		chk(BIT_RESULT.range_err, ee);
		chk(BIT_RESULT.is_reg, m == opvd_pkg::OPVD_BIT_REG);
	endtask

	task automatic lchk(input opvd_pkg::opvd_fmt_t f, input logic [1:0] s, input logic [1:0] d,
			input logic p8, input logic [15:0] op, input logic sg, input logic wd,
			input logic [15:0] dat, input logic [3:0] et, input logic [7:0] ei, input logic ee,
			input logic [16:0] ev);
		@(posedge CLK);
		LEN_REQ  <= 1'b1;
		LEN_ARGS <= '{f, s, d, p8, op, sg, wd, dat};
		step();
		chk(LEN_VALID, 1'b1);
		chk(LEN_RESULT.len_err, ee);
		chk(LEN_RESULT.int_value, ev);
		if (!ee)
			chk(LEN_RESULT.total, et);
		if (f == opvd_pkg::OPVD_FMT_Q || f == opvd_pkg::OPVD_FMT_Z)
			chk(LEN_RESULT.imm, ei);
	endtask

	task automatic schk(input opvd_pkg::opvd_str_op_t op, input logic w, input logic [19:0] a,
			input logic [15:0] c, input logic [19:0] ea, input logic [15:0] ec, input logic ed);
		@(posedge CLK);
		STR_REQ   <= 1'b1;
		STR_OP    <= op;
		STR_WORD  <= w;
		STR_ADDR  <= a;
		STR_COUNT <= c;
		step();
		chk(STR_VALID, 1'b1);
		chk(STR_NEXT_ADDR, ea);
		chk(STR_NEXT_COUNT, ec);
		chk(STR_DONE, ed);
		chk(STR_ELEM_BYTES, w ? 2'h2 : 2'h1);
	endtask

	// Little-endian assembly of the bytes the memory model holds at the entry.
	function automatic logic [19:0] hexp(input logic [19:0] a, input logic sp);
		logic [7:0] b0;
		logic [7:0] b1;
		logic [7:0] b2;
		b0 = a[7:0] ^ 8'h5a;
		b1 = (a[7:0] + 8'h01) ^ 8'h5a;
		b2 = (a[7:0] + 8'h02) ^ 8'h5a;
		return sp ? {4'hf, b1, b0} : {b2[3:0], b1, b0};
	endfunction

	task automatic vchk(input opvd_pkg::opvd_vec_kind_t k, input logic [7:0] n,
			input logic [19:0] ea, input logic ee);
		int i;
		@(posedge CLK);
		VEC_REQ  <= 1'b1;
		VEC_KIND <= k;
		VEC_NUM  <= n;
		i = 0;
		do
		begin
			step();
			i++;
		end
		while (VEC_DONE !== 1'b1 && i < 100);
		if (VEC_DONE !== 1'b1)
		begin
			num_errors++;
			test_done();
		end
		else
		begin
			chk(VEC_ERR, ee);
			chk(VEC_BUSY, 1'b0);
			if (!ee)
			begin
				chk(VEC_ENTRY_ADDR, ea);
				chk(VEC_HANDLER, hexp(ea, k == opvd_pkg::OPVD_VEC_SPECIAL));
			end
		end
	endtask

	initial
	begin
		{RST, BIT_REQ, LEN_REQ, STR_REQ, STR_WORD, TBASE_WE, VEC_REQ, slow} = 8'h80;
		{BIT_ARGS, LEN_ARGS, STR_ADDR, STR_COUNT, TBASE_WDATA, VEC_NUM} = '0;
		STR_OP = opvd_pkg::OPVD_STR_FWD;
		VEC_KIND = opvd_pkg::OPVD_VEC_SPECIAL;
		repeat (6) @(posedge CLK);
		RST <= 1'b0;
		step();
		chk(TBASE_VALUE, 20'h00000);
		bchk(opvd_pkg::OPVD_BIT_REG, opvd_pkg::OPVD_BASE8,
			16'h0, 16'h000f, 16'h0, 20'h0, 4'hf, 0);
		bchk(opvd_pkg::OPVD_BIT_REG, opvd_pkg::OPVD_BASE8,
			16'h0, 16'h0010, 16'h0, 20'h0, 4'h0, 1);
		bchk(opvd_pkg::OPVD_BIT_ABS, opvd_pkg::OPVD_BASE16,
			16'h000a, 16'h2, 16'h0, 20'h0a, 4'h2, 0);
		bchk(opvd_pkg::OPVD_BIT_ABS, opvd_pkg::OPVD_BASE16,
			16'h1ff0, 16'h80, 16'h0, 20'h2000, 4'h0, 1);
		bchk(opvd_pkg::OPVD_BIT_STATIC, opvd_pkg::OPVD_BASE8,
			16'h1f, 16'h7, 16'h400, 20'h41f, 4'h7, 0);
		bchk(opvd_pkg::OPVD_BIT_STATIC, opvd_pkg::OPVD_BASE8,
			16'h1f, 16'h8, 16'h400, 20'h420, 4'h0, 1);
		bchk(opvd_pkg::OPVD_BIT_STATIC, opvd_pkg::OPVD_BASE11,
			16'h0ff, 16'h7, 16'h400, 20'h4ff, 4'h7, 0);
		bchk(opvd_pkg::OPVD_BIT_STATIC, opvd_pkg::OPVD_BASE11,
			16'h0ff, 16'h8, 16'h400, 20'h500, 4'h0, 1);
		bchk(opvd_pkg::OPVD_BIT_STATIC, opvd_pkg::OPVD_BASE16,
			16'h1ff0, 16'h7f, 16'h0, 20'h1fff, 4'h7, 0);
		bchk(opvd_pkg::OPVD_BIT_FRAME, opvd_pkg::OPVD_BASE8,
			16'hf0, 16'h3, 16'h100, 20'hf0, 4'h3, 0);
		bchk(opvd_pkg::OPVD_BIT_FRAME, opvd_pkg::OPVD_BASE8,
			16'h0f, 16'h8, 16'h100, 20'h110, 4'h0, 1);
		bchk(opvd_pkg::OPVD_BIT_AN_IND, opvd_pkg::OPVD_BASE8,
			16'h0, 16'h0, 16'h52, 20'h0a, 4'h2, 0);
		bchk(opvd_pkg::OPVD_BIT_AN_REL, opvd_pkg::OPVD_BASE8,
			16'h20, 16'h0, 16'h13, 20'h22, 4'h3, 0);
		lchk(opvd_pkg::OPVD_FMT_G, 2'h3, 2'h3, 0, 16'h0, 1, 1, 16'h8000,
			4'h8, 8'h0, 0, 17'h18000);
		lchk(opvd_pkg::OPVD_FMT_Q, 2'h0, 2'h2, 0, 16'h90, 0, 0, 16'h00ff,
			4'h4, 8'hf9, 0, 17'h000ff);
		lchk(opvd_pkg::OPVD_FMT_Q, 2'h0, 2'h0, 1, 16'h80, 0, 0, 16'h0,
			4'h2, 8'h08, 0, 17'h0);
		lchk(opvd_pkg::OPVD_FMT_Q, 2'h0, 2'h3, 0, 16'h10, 0, 0, 16'h0,
			4'h0, 8'h01, 1, 17'h0);
		lchk(opvd_pkg::OPVD_FMT_S, 2'h2, 2'h2, 0, 16'h0, 1, 0, 16'h1280,
			4'h5, 8'h0, 0, 17'h1ff80);
		lchk(opvd_pkg::OPVD_FMT_S, 2'h3, 2'h0, 0, 16'h0, 0, 0, 16'h0,
			4'h0, 8'h0, 1, 17'h0);
		lchk(opvd_pkg::OPVD_FMT_Z, 2'h0, 2'h2, 0, 16'hff, 0, 0, 16'h0,
			4'h3, 8'h00, 0, 17'h0);
		schk(opvd_pkg::OPVD_STR_BWD, 1, 20'h100, 16'h1, 20'h0fe, 16'h0, 1);
		schk(opvd_pkg::OPVD_STR_FWD, 0, 20'h100, 16'h5, 20'h101, 16'h4, 0);
		schk(opvd_pkg::OPVD_STR_FILL, 1, 20'h100, 16'h3, 20'h102, 16'h2, 0);
		schk(opvd_pkg::OPVD_STR_FWD, 0, 20'h200, 16'h0, 20'h200, 16'h0, 1);
		@(posedge CLK);
		TBASE_WE    <= 1'b1;
		TBASE_WDATA <= 20'h12340;
		step();
		chk(TBASE_VALUE, 20'h12340);
		vchk(opvd_pkg::OPVD_VEC_SPECIAL, 8'd18, 20'hfffda, 0);
		vchk(opvd_pkg::OPVD_VEC_SPECIAL, 8'd255, 20'hffe00, 0);
		vchk(opvd_pkg::OPVD_VEC_SPECIAL, 8'd17, 20'h0, 1);
		vchk(opvd_pkg::OPVD_VEC_FIXED, 8'd0, 20'hfffdc, 0);
		vchk(opvd_pkg::OPVD_VEC_FIXED, 8'd8, 20'hffffc, 0);
		vchk(opvd_pkg::OPVD_VEC_FIXED, 8'd9, 20'h0, 1);
		vchk(opvd_pkg::OPVD_VEC_SOFT, 8'd63, 20'h1243c, 0);
		vchk(opvd_pkg::OPVD_VEC_SOFT, 8'd64, 20'h0, 1);
		vchk(opvd_pkg::OPVD_VEC_PERIPH, 8'd31, 20'h123bc, 0);
		vchk(opvd_pkg::OPVD_VEC_PERIPH, 8'd32, 20'h0, 1);
		slow = 1'b1;
		vchk(opvd_pkg::OPVD_VEC_SOFT, 8'd0, 20'h12340, 0);
		test_done();
	end
endmodule
`default_nettype wire
